// File: hw/gtcr_pkg.sv
// package: register map, field positions, reset values and timing for the general timer
package gtcr_pkg;
    localparam logic [7:0] ADDR_CONTROL = 8'hC0;
    localparam logic [7:0] ADDR_MODE = 8'hC1;
    localparam logic [7:0] ADDR_RC_LOW = 8'hC2;
    localparam logic [7:0] ADDR_RC_HIGH = 8'hC3;
    localparam logic [7:0] ADDR_CNT_LOW = 8'hC4;
    localparam logic [7:0] ADDR_CNT_HIGH = 8'hC5;
    localparam logic [7:0] ADDR_IRQ_EN = 8'hC6;
    localparam logic [7:0] ADDR_INSEL_A = 8'hC7;
    localparam logic [7:0] ADDR_INSEL_B = 8'hC8;
    localparam logic [7:0] ADDR_PWR_A = 8'hC9;
    localparam logic [7:0] ADDR_PWR_B = 8'hCA;
    localparam logic [7:0] ADDR_SUSP = 8'hCB;
    // control fields
    localparam int CTL_CAPTURE = 0;
    localparam int CTL_COUNTER = 1;
    localparam int CTL_RUN = 2;
    localparam int CTL_EVENT_EN = 3;
    localparam int CTL_EXT_FLAG = 6;
    localparam int CTL_OVF_FLAG = 7;
    localparam logic [7:0] CTL_MASK = 8'hCF;
    // mode fields
    localparam int MOD_UPDOWN = 0;
    localparam int MOD_PRE_LSB = 1;
    localparam int MOD_PRESCALER_ENABLE = 4;
    localparam int MOD_CAP_EDGE = 5;
    localparam int MOD_START_EN = 6;
    localparam int MOD_START_EDGE = 7;
    // enables
    localparam int IEN_EXT = 0;
    localparam int IEN_OVF = 1;
    localparam logic [7:0] IEN_MASK = 8'h03;
    // input select, power, suspend
    localparam int INSEL_COUNT = 2;
    localparam int INSEL_COUNT2 = 3;
    localparam int INSEL_EVENT = 4;
    localparam logic [7:0] INSEL_A_MASK = 8'h1F;
    localparam int INSEL_EVENT2 = 2;
    localparam logic [7:0] INSEL_B_MASK = 8'hFC;
    localparam int PWR_DISABLE = 3;
    localparam logic [7:0] PWR_A_MASK = 8'h7F;
    localparam int PWR2_DISABLE = 0;
    localparam logic [7:0] PWR_B_MASK = 8'h03;
    localparam int SUSP_BIT = 3;
    localparam int SUSP2_BIT = 4;
    localparam logic [7:0] SUSP_MASK = 8'h3F;
    // reset values
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_IRQ_EN = 8'h03;
    localparam logic [7:0] RST_SUSP = 8'h01;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    // fixed timer divider
    localparam int FIXED_DIV = 12;
endpackage : gtcr_pkg

// File: hw/gtcr_timer.sv
// general timer with capture and auto-reload, register port and pin sampling
`timescale 1ns/1ps
module gtcr_timer #(
    parameter logic MAPPED_AREA = 1'b0
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_mapped_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic count_pin0_i,
    input wire logic count_pin1_i,
    input wire logic event_pin0_i,
    input wire logic event_pin1_i,
    input wire logic debug_monitor_i,
    output logic [7:0] reg_rdata_o,
    output logic irq_o,
    output logic overflow_o
);
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] mode;
        logic [15:0] reload;
        logic [15:0] count;
        logic [7:0] irq_en;
        logic [7:0] insel_a;
        logic [7:0] insel_b;
        logic [7:0] pwr_a;
        logic [7:0] pwr_b;
        logic [7:0] susp;
        logic [3:0] div12;
        logic [6:0] presc;
        logic [1:0] cnt0_sync;
        logic [1:0] cnt1_sync;
        logic cnt_prev;
        logic [1:0] evt0_sync;
        logic [1:0] evt1_sync;
        logic evt_prev;
        logic [7:0] rdata;
        logic irq;
        logic ovf_pulse;
    } gtcr_state_type;

    gtcr_state_type state_reg;
    gtcr_state_type state_next;

    // byte lane decode shared by read and write paths
    function automatic logic gtcr_hit(input logic [7:0] a, input logic [7:0] off, input logic mapped);
        gtcr_hit = (a == off) && (mapped == MAPPED_AREA);
    endfunction : gtcr_hit

    // edge helpers shared by the count and event pins
    function automatic logic gtcr_rose(input logic prev, input logic cur);
        gtcr_rose = !prev && cur;
    endfunction : gtcr_rose

    function automatic logic gtcr_fell(input logic prev, input logic cur);
        gtcr_fell = prev && !cur;
    endfunction : gtcr_fell

    logic sel_cnt_pin;
    logic sel_evt_pin;
    logic evt_rise;
    logic evt_fall;
    logic cap_edge;
    logic start_edge;
    logic tick;
    logic active;
    logic presc_tick;
    logic [7:0] presc_mask;
    logic ovf;
    logic down;
    logic [15:0] cnt_inc;
    logic [3:0] div_last;
    logic [7:0] hw_set;

    assign div_last = 4'(gtcr_pkg::FIXED_DIV - 1);

    always_comb begin
        state_next = state_reg;
        hw_set = 8'h00;
        // every pin synchronised on its own, the choice made on clean levels
        state_next.cnt0_sync = {state_reg.cnt0_sync[0], count_pin0_i};
        state_next.cnt1_sync = {state_reg.cnt1_sync[0], count_pin1_i};
        state_next.evt0_sync = {state_reg.evt0_sync[0], event_pin0_i};
        state_next.evt1_sync = {state_reg.evt1_sync[0], event_pin1_i};
        // switching the source may show one false edge; switch while stopped
        sel_cnt_pin = state_reg.insel_a[gtcr_pkg::INSEL_COUNT] ? state_reg.cnt1_sync[1]
            : state_reg.cnt0_sync[1];
        sel_evt_pin = state_reg.insel_a[gtcr_pkg::INSEL_EVENT] ? state_reg.evt1_sync[1]
            : state_reg.evt0_sync[1];
        state_next.cnt_prev = sel_cnt_pin;
        state_next.evt_prev = sel_evt_pin;
        evt_rise = gtcr_rose(state_reg.evt_prev, sel_evt_pin);
        evt_fall = gtcr_fell(state_reg.evt_prev, sel_evt_pin);
        cap_edge = state_reg.mode[gtcr_pkg::MOD_CAP_EDGE] ? evt_rise : evt_fall;
        start_edge = state_reg.mode[gtcr_pkg::MOD_START_EDGE] ? evt_rise : evt_fall;
        // disabled clock freezes prescaler, divider, count, start and capture; pin synchronisers keep sampling; registers stay accessible
        active = !state_reg.pwr_a[gtcr_pkg::PWR_DISABLE];

        // prescaler and fixed divider run freely while enabled
        presc_mask = 8'((9'h001 << state_reg.mode[gtcr_pkg::MOD_PRE_LSB +: 3]) - 9'h001);
        presc_tick = ({1'b0, state_reg.presc} & presc_mask) == presc_mask;
        if (active) begin
            state_next.presc = state_reg.presc + 7'h01;
            state_next.div12 = (state_reg.div12 == div_last) ? 4'h0 : state_reg.div12 + 4'h1;
        end
        if (state_reg.control[gtcr_pkg::CTL_COUNTER]) begin
            tick = gtcr_fell(state_reg.cnt_prev, sel_cnt_pin);
        end else if (state_reg.mode[gtcr_pkg::MOD_PRESCALER_ENABLE]) begin
            tick = presc_tick;
        end else begin
            tick = state_reg.div12 == div_last;
        end
        tick = tick && active && state_reg.control[gtcr_pkg::CTL_RUN]
            && !(state_reg.susp[gtcr_pkg::SUSP_BIT] && debug_monitor_i);

        down = state_reg.mode[gtcr_pkg::MOD_UPDOWN] && !state_reg.control[gtcr_pkg::CTL_CAPTURE]
            && !sel_evt_pin;
        ovf = 1'b0;
        cnt_inc = state_reg.count;
        state_next.ovf_pulse = 1'b0;
        if (tick) begin
            if (down) begin
                if (state_reg.count == state_reg.reload) begin
                    ovf = 1'b1;
                    cnt_inc = gtcr_pkg::CNT_MAX;
                end else begin
                    cnt_inc = state_reg.count - 16'h0001;
                end
            end else if (state_reg.count == gtcr_pkg::CNT_MAX) begin
                ovf = 1'b1;
                cnt_inc = state_reg.control[gtcr_pkg::CTL_CAPTURE] ? gtcr_pkg::CNT_ZERO
                    : state_reg.reload;
            end else begin
                cnt_inc = state_reg.count + 16'h0001;
            end
        end
        state_next.count = cnt_inc;
        if (ovf) begin
            state_next.control[gtcr_pkg::CTL_OVF_FLAG] = 1'b1;
            hw_set[gtcr_pkg::CTL_OVF_FLAG] = 1'b1;
            state_next.ovf_pulse = 1'b1;
            if (state_reg.mode[gtcr_pkg::MOD_UPDOWN] && !state_reg.control[gtcr_pkg::CTL_CAPTURE]) begin
                state_next.control[gtcr_pkg::CTL_EXT_FLAG] = !state_reg.control[gtcr_pkg::CTL_EXT_FLAG];
                hw_set[gtcr_pkg::CTL_EXT_FLAG] = !state_reg.control[gtcr_pkg::CTL_EXT_FLAG];
            end
        end

        // event pin: start, then capture or reload
        if (active && state_reg.mode[gtcr_pkg::MOD_START_EN] && !state_reg.control[gtcr_pkg::CTL_RUN]
            && start_edge) begin
            state_next.control[gtcr_pkg::CTL_RUN] = 1'b1;
            hw_set[gtcr_pkg::CTL_RUN] = 1'b1;
            if (state_reg.control[gtcr_pkg::CTL_EVENT_EN]) begin
                state_next.control[gtcr_pkg::CTL_EXT_FLAG] = 1'b1;
                hw_set[gtcr_pkg::CTL_EXT_FLAG] = 1'b1;
            end
        end else if (active && state_reg.control[gtcr_pkg::CTL_EVENT_EN] && cap_edge
            && !state_reg.mode[gtcr_pkg::MOD_UPDOWN]) begin
            // stopped timer gets the same capture or reload, with the same flag effect
            state_next.control[gtcr_pkg::CTL_EXT_FLAG] = 1'b1;
            hw_set[gtcr_pkg::CTL_EXT_FLAG] = 1'b1;
            if (state_reg.control[gtcr_pkg::CTL_CAPTURE]) begin
                state_next.reload = cnt_inc;
            end else begin
                state_next.count = state_reg.reload;
            end
        end

        // software writes; hardware sets above win over clears of flags
        if (reg_wr_i) begin
            if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_CONTROL, reg_mapped_i)) begin
                // a flag raised in this very cycle survives a clearing write, even if already set
                state_next.control = (reg_wdata_i & gtcr_pkg::CTL_MASK) | hw_set;
            end
            if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_MODE, reg_mapped_i)) begin
                state_next.mode = reg_wdata_i;
            end
            if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_RC_LOW, reg_mapped_i)) begin
                state_next.reload[7:0] = reg_wdata_i;
            end
            if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_RC_HIGH, reg_mapped_i)) begin
                state_next.reload[15:8] = reg_wdata_i;
            end
            if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_CNT_LOW, reg_mapped_i)) begin
                state_next.count[7:0] = reg_wdata_i;
            end
            if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_CNT_HIGH, reg_mapped_i)) begin
                state_next.count[15:8] = reg_wdata_i;
            end
            if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_IRQ_EN, reg_mapped_i)) begin
                state_next.irq_en = reg_wdata_i & gtcr_pkg::IEN_MASK;
            end
            if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_INSEL_A, reg_mapped_i)) begin
                state_next.insel_a = reg_wdata_i & gtcr_pkg::INSEL_A_MASK;
            end
            if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_INSEL_B, reg_mapped_i)) begin
                state_next.insel_b = reg_wdata_i & gtcr_pkg::INSEL_B_MASK;
            end
            if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_PWR_A, reg_mapped_i)) begin
                state_next.pwr_a = reg_wdata_i & gtcr_pkg::PWR_A_MASK;
            end
            if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_PWR_B, reg_mapped_i)) begin
                state_next.pwr_b = reg_wdata_i & gtcr_pkg::PWR_B_MASK;
            end
            if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_SUSP, reg_mapped_i)) begin
                state_next.susp = reg_wdata_i & gtcr_pkg::SUSP_MASK;
            end
        end

        // registered read data, zero for unmapped
        state_next.rdata = 8'h00;
        if (reg_rd_i) begin
            if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_CONTROL, reg_mapped_i)) begin
                state_next.rdata = state_reg.control & gtcr_pkg::CTL_MASK;
            end else if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_MODE, reg_mapped_i)) begin
                state_next.rdata = state_reg.mode;
            end else if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_RC_LOW, reg_mapped_i)) begin
                state_next.rdata = state_reg.reload[7:0];
            end else if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_RC_HIGH, reg_mapped_i)) begin
                state_next.rdata = state_reg.reload[15:8];
            end else if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_CNT_LOW, reg_mapped_i)) begin
                state_next.rdata = state_reg.count[7:0];
            end else if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_CNT_HIGH, reg_mapped_i)) begin
                state_next.rdata = state_reg.count[15:8];
            end else if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_IRQ_EN, reg_mapped_i)) begin
                state_next.rdata = state_reg.irq_en;
            end else if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_INSEL_A, reg_mapped_i)) begin
                state_next.rdata = state_reg.insel_a;
            end else if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_INSEL_B, reg_mapped_i)) begin
                state_next.rdata = state_reg.insel_b;
            end else if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_PWR_A, reg_mapped_i)) begin
                state_next.rdata = state_reg.pwr_a;
            end else if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_PWR_B, reg_mapped_i)) begin
                state_next.rdata = state_reg.pwr_b;
            end else if (gtcr_hit(reg_addr_i, gtcr_pkg::ADDR_SUSP, reg_mapped_i)) begin
                state_next.rdata = state_reg.susp;
            end
        end

        // updown keeps the external flag out of the request
        state_next.irq = (state_next.control[gtcr_pkg::CTL_OVF_FLAG] && state_next.irq_en[gtcr_pkg::IEN_OVF])
            || (state_next.control[gtcr_pkg::CTL_EXT_FLAG] && state_next.irq_en[gtcr_pkg::IEN_EXT]
            && !state_next.mode[gtcr_pkg::MOD_UPDOWN]);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            state_reg <= '0;
            state_reg.control <= gtcr_pkg::RST_CONTROL;
            state_reg.mode <= gtcr_pkg::RST_MODE;
            state_reg.irq_en <= gtcr_pkg::RST_IRQ_EN;
            state_reg.insel_a <= gtcr_pkg::RST_ZERO;
            state_reg.insel_b <= gtcr_pkg::RST_ZERO;
            state_reg.pwr_a <= gtcr_pkg::RST_ZERO;
            state_reg.pwr_b <= gtcr_pkg::RST_ZERO;
            state_reg.susp <= gtcr_pkg::RST_SUSP;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_o = state_reg.rdata;
    assign irq_o = state_reg.irq;
    assign overflow_o = state_reg.ovf_pulse;
endmodule : gtcr_timer

// File: sim/gtcr_timer_properties.sv
// checker: register and flag relations at the general timer ports
`timescale 1ns/1ps
module gtcr_timer_properties #(
    parameter logic MAPPED_AREA = 1'b0
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_mapped_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic count_pin0_i,
    input wire logic count_pin1_i,
    input wire logic event_pin0_i,
    input wire logic event_pin1_i,
    input wire logic debug_monitor_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic irq_o,
    input wire logic overflow_o
);
    logic hit;
    logic [7:0] ien_reg;
    logic [7:0] ien_next;
    assign hit = reg_rd_i && reg_mapped_i == MAPPED_AREA;
    // enables shadowed from writes alone, so the irq relation needs no internal view
    assign ien_next = (reg_wr_i && reg_mapped_i == MAPPED_AREA && reg_addr_i == gtcr_pkg::ADDR_IRQ_EN)
        ? reg_wdata_i : ien_reg;
    always_ff @(posedge clk_sys_i) begin
        ien_reg <= !nrst_i ? gtcr_pkg::RST_IRQ_EN : ien_next;
    end
    default clocking dc @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    a_ctl_reserved_zero: assert property ($past(hit) && $past(reg_addr_i) == gtcr_pkg::ADDR_CONTROL
        |-> (reg_rdata_o & ~gtcr_pkg::CTL_MASK) == 8'h00) else $error("control reserved bits nonzero");
    a_ien_reserved_zero: assert property ($past(hit) && $past(reg_addr_i) == gtcr_pkg::ADDR_IRQ_EN
        |-> (reg_rdata_o & ~gtcr_pkg::IEN_MASK) == 8'h00) else $error("enable reserved bits nonzero");
    a_insel_reserved_zero: assert property ($past(hit) && $past(reg_addr_i) == gtcr_pkg::ADDR_INSEL_B
        |-> reg_rdata_o[1:0] == 2'b00) else $error("input select reserved bits nonzero");
    a_susp_reserved_zero: assert property ($past(hit) && $past(reg_addr_i) == gtcr_pkg::ADDR_SUSP
        |-> reg_rdata_o[7:6] == 2'b00) else $error("suspend reserved bits nonzero");
    a_other_area_quiet: assert property ($past(reg_rd_i) && ($past(reg_mapped_i) != MAPPED_AREA
        || $past(reg_addr_i) > gtcr_pkg::ADDR_SUSP) |-> reg_rdata_o == 8'h00) else $error("foreign read not zero");
    a_irq_falls_write: assert property ($fell(irq_o) |-> $past(reg_wr_i))
        else $error("irq dropped without a software write");
    a_ovf_raises_irq: assert property (overflow_o && ien_reg[gtcr_pkg::IEN_OVF] && !$past(reg_wr_i)
        |-> irq_o) else $error("enabled overflow gave no irq");
    a_mode_holds_value: assert property (
        (hit && !reg_wr_i && reg_addr_i == gtcr_pkg::ADDR_MODE) ##1 !reg_wr_i ##1 (hit && reg_addr_i ==
        gtcr_pkg::ADDR_MODE) |=> reg_rdata_o == $past(reg_rdata_o, 2)) else $error("mode changed by itself");
endmodule : gtcr_timer_properties
bind gtcr_timer gtcr_timer_properties #(.MAPPED_AREA(MAPPED_AREA)) u_props (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_mapped_i(reg_mapped_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .count_pin0_i(count_pin0_i), .count_pin1_i(count_pin1_i),
    .event_pin0_i(event_pin0_i), .event_pin1_i(event_pin1_i), .debug_monitor_i(debug_monitor_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .overflow_o(overflow_o));

// File: sim/gtcr_pin_source.sv
// pin source model: count and external event levels on the pin pair chosen by use_alt_i, noise on the other pair
`timescale 1ns/1ps
module gtcr_pin_source (
    input wire logic clk_sys_i,
    input wire logic use_alt_i,
    output logic count_pin0_o,
    output logic count_pin1_o,
    output logic event_pin0_o,
    output logic event_pin1_o
);
    logic count_lvl = 1'b1;
    logic event_lvl = 1'b0;
    logic noise = 1'b0;
    // unselected pair toggles every clock, so a wrong pin choice shows up
    always @(posedge clk_sys_i) begin
        noise <= ~noise;
    end
    assign count_pin0_o = use_alt_i ? noise : count_lvl;
    assign count_pin1_o = use_alt_i ? count_lvl : noise;
    assign event_pin0_o = use_alt_i ? noise : event_lvl;
    assign event_pin1_o = use_alt_i ? event_lvl : noise;
    task automatic set_levels(input logic count_level, input logic event_level);
        @(posedge clk_sys_i);
        count_lvl <= count_level;
        event_lvl <= event_level;
        repeat (4) @(posedge clk_sys_i);
    endtask : set_levels
endmodule : gtcr_pin_source

// File: sim/test_general_timer_capture_reload.sv
// bench: registers, capture, overflow, external start, disable and suspend
`timescale 1ns/1ps
`define GTCR_CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
    $display("Error at %0t: got %h, expected %h", $time, got, exp); end end
module test_general_timer_capture_reload;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic mapped = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic dbg = 1'b0;
    logic alt = 1'b0;
    wire [3:0] pin;
    logic [7:0] rdata;
    logic irq;
    logic ovf;
    logic [7:0] notes[$];
    logic seen = 1'b0;
    logic [15:0] cnt;
    logic [15:0] fields[6] = '{16'hC0CF, 16'hC603, 16'hC71F, 16'hC8FC, 16'hCA03, 16'hCB3F};
    int errors = 0;
    int total_checks = 0;
    int seed = 62;
    int n = 0;
    logic [7:0] expect_rd = 8'h00;
    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    gtcr_timer #(.MAPPED_AREA(1'b0)) DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(addr),
        .reg_mapped_i(mapped), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .count_pin0_i(pin[0]),
        .count_pin1_i(pin[1]), .event_pin0_i(pin[2]), .event_pin1_i(pin[3]), .debug_monitor_i(dbg),
        .reg_rdata_o(rdata), .irq_o(irq), .overflow_o(ovf));
    gtcr_pin_source pins (.clk_sys_i(clk_sys_i), .use_alt_i(alt), .count_pin0_o(pin[0]),
        .count_pin1_o(pin[1]), .event_pin0_o(pin[2]), .event_pin1_o(pin[3]));
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        mapped <= 1'b0;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask : wr8
    task automatic rd8(input logic [7:0] a, input logic [7:0] e, input logic area = 1'b0);
        notes.push_back(e);
        @(posedge clk_sys_i);
        addr <= a;
        mapped <= area;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
    endtask : rd8
    // clocks from the run write until the overflow pulse is seen, capped at 64
    task automatic time_ovf(output int cycles);
        cycles = 0;
        while (ovf !== 1'b1 && cycles < 64) begin
            @(negedge clk_sys_i);
            cycles++;
        end
    endtask : time_ovf
    task automatic wrap_up();
        $display("checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    // read data stands one cycle only, so it is taken at the very next edge
    always @(posedge clk_sys_i) begin
        seen <= rd;
        if (seen) begin
            expect_rd = notes.pop_front();
            `GTCR_CHECK(rdata, expect_rd)
        end
    end
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        errors++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            rd8(8'hC0 + 8'(i), i == 6 ? 8'h03 : (i == 11 ? 8'h01 : 8'h00));
        end
        rd8(8'hCC, 8'h00);
        rd8(8'hC6, 8'h00, 1'b1);
        foreach (fields[i]) begin
            wr8(fields[i][15:8], 8'hFF);
            rd8(fields[i][15:8], fields[i][7:0]);
            wr8(fields[i][15:8], fields[i][15:8] == 8'hC6 ? 8'h03 : 8'h00);
        end
        cnt = (16'($random(seed)) & 16'h7FF0) | 16'h4000;
        alt <= 1'b1;
        wr8(8'hC7, 8'h14);
        wr8(8'hC4, cnt[7:0]);
        wr8(8'hC5, cnt[15:8]);
        wr8(8'hC1, 8'h20);
        wr8(8'hC0, 8'h0F);
        pins.set_levels(1'b0, 1'b0);
        pins.set_levels(1'b1, 1'b0);
        pins.set_levels(1'b0, 1'b1);
        cnt = cnt + 16'd2;
        rd8(8'hC2, cnt[7:0]);
        rd8(8'hC3, cnt[15:8]);
        rd8(8'hC4, cnt[7:0]);
        rd8(8'hC0, 8'h4F);
        `GTCR_CHECK(irq, 1'b1)
        wr8(8'hC0, 8'h0F);
        pins.set_levels(1'b1, 1'b0);
        rd8(8'hC0, 8'h0F);
        `GTCR_CHECK(irq, 1'b0)
        wr8(8'hC0, 8'h09);
        wr8(8'hC1, 8'h30);
        rd8(8'hC1, 8'h30);
        rd8(8'hC1, 8'h30);
        wr8(8'hC4, 8'hF0);
        wr8(8'hC5, 8'hFF);
        wr8(8'hC0, 8'h0D);
        time_ovf(n);
        `GTCR_CHECK(n, 17)
        `GTCR_CHECK(ovf, 1'b1)
        `GTCR_CHECK(irq, 1'b1)
        rd8(8'hC5, 8'h00);
        rd8(8'hC0, 8'h8D);
        wr8(8'hC0, 8'h08);
        wr8(8'hC1, 8'h50);
        wr8(8'hC2, 8'h00);
        wr8(8'hC3, 8'h12);
        pins.set_levels(1'b1, 1'b1);
        pins.set_levels(1'b1, 1'b0);
        rd8(8'hC0, 8'h4C);
        wr8(8'hC0, 8'h0C);
        pins.set_levels(1'b1, 1'b1);
        pins.set_levels(1'b1, 1'b0);
        rd8(8'hC5, 8'h12);
        rd8(8'hC0, 8'h4C);
        wr8(8'hC0, 8'h0C);
        wr8(8'hC9, 8'h08);
        pins.set_levels(1'b1, 1'b1);
        pins.set_levels(1'b1, 1'b0);
        rd8(8'hC0, 8'h0C);
        wr8(8'hC9, 8'h00);
        wr8(8'hC0, 8'h00);
        wr8(8'hC1, 8'h14);
        wr8(8'hC4, 8'hFE);
        wr8(8'hC5, 8'hFF);
        wr8(8'hC0, 8'h04);
        time_ovf(n);
        `GTCR_CHECK(n >= 6 && n <= 9, 1'b1)
        wr8(8'hC0, 8'h00);
        wr8(8'hC1, 8'h00);
        wr8(8'hC4, 8'hFE);
        wr8(8'hC5, 8'hFF);
        wr8(8'hC0, 8'h04);
        time_ovf(n);
        `GTCR_CHECK(n >= 14 && n <= 25, 1'b1)
        rd8(8'hC5, 8'h12);
        wr8(8'hC0, 8'h00);
        wr8(8'hC1, 8'h11);
        wr8(8'hC4, 8'h02);
        wr8(8'hC5, 8'h12);
        wr8(8'hC0, 8'h04);
        time_ovf(n);
        `GTCR_CHECK(n, 4)
        rd8(8'hC5, 8'hFF);
        rd8(8'hC0, 8'hC4);
        wr8(8'hC0, 8'h40);
        @(negedge clk_sys_i);
        `GTCR_CHECK(irq, 1'b0)
        wr8(8'hC1, 8'h10);
        @(negedge clk_sys_i);
        `GTCR_CHECK(irq, 1'b1)
        wr8(8'hC0, 8'h08);
        pins.set_levels(1'b1, 1'b1);
        pins.set_levels(1'b1, 1'b0);
        rd8(8'hC0, 8'h48);
        wr8(8'hC0, 8'h08);
        wr8(8'hC4, 8'h55);
        wr8(8'hC5, 8'h00);
        wr8(8'hCB, 8'h09);
        wr8(8'hC0, 8'h04);
        dbg <= 1'b1;
        repeat (300) @(posedge clk_sys_i);
        rd8(8'hC5, 8'h00);
        dbg <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        wrap_up();
    end
endmodule : test_general_timer_capture_reload
